// file: include/rate_table_regs.svh
// Register indices, field positions, reset values and timing counts for the
// ingress rate table access block. Assumes a word-indexed switch register port.
`ifndef RATE_TABLE_REGS_SVH
`define RATE_TABLE_REGS_SVH

`define RATE_TABLE_COMMAND_IDX    16'h184b
`define RATE_CMD_STATUS_IDX       16'h184c
`define RATE_WRITE_DATA_IDX       16'h184d
`define RATE_READ_DATA_IDX        16'h184e
`define PORT0_FILTERED_COUNT_IDX  16'h1850

`define CMD_DIR_BIT               7
`define CMD_TYPE_HI               6
`define CMD_TYPE_LO               5
`define CMD_ADDR_HI               4
`define CMD_ADDR_LO               0
`define STATUS_PENDING_BIT        0

`define TYPE_RESERVED             2'h0
`define TYPE_COMMITTED_RATE       2'h1
`define TYPE_COMMITTED_BURST      2'h2
`define TYPE_EXCESS_BURST         2'h3

`define RATE_ENTRIES              24
`define RATE_ENTRY_RESET          16'h0014
`define BURST_SIZE_RESET          16'h0600
`define RATE_TICK_NS              20
`define COUNT_MAX                 32'hffff_ffff

// Table access latency: pending stays high this many cycles
`define RATE_ACCESS_CYCLES        2'h2

`endif

// file: include/rate_table_pkg.sv
// Types for the ingress rate table access block.
// Assumes rate_table_regs.svh is on the include path.
`include "rate_table_regs.svh"

package rate_table_pkg;

  typedef enum logic {ACC_IDLE, ACC_BUSY} access_state_t;

  typedef logic [`RATE_ENTRIES-1:0][15:0] rate_table_t;

  typedef struct packed {
    access_state_t st;
    logic [1:0] lat;
    logic [7:0] command;
    logic [15:0] write_data;
    logic [15:0] read_data;
    rate_table_t committed_rate_entry;
    logic [15:0] committed_burst_size;
    logic [15:0] excess_burst_size;
    logic [31:0] filtered_count;
    logic [31:0] rsp_data;
    logic rsp_valid;
    logic [15:0] committed_tokens;
    logic [15:0] excess_tokens;
  } rate_state_t;

endpackage

// file: verilog/ingress_rate_table_access.sv
// Ingress rate metering table with indirect command access, plus the port 0
// ingress filtered-packet counter. Assumes a single clock, a word-indexed
// register port driven from the same clock, and meter events from same domain.
`include "rate_table_regs.svh"

module ingress_rate_table_access (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic [15:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic pkt_filtered,
  input wire logic tok_refill,
  input wire logic tok_consume,
  input wire logic [15:0] tok_bytes,
  output rate_table_pkg::rate_table_t committed_rate_table,
  output logic [15:0] committed_burst,
  output logic [15:0] excess_burst,
  output logic [15:0] committed_tokens,
  output logic [15:0] excess_tokens,
  output logic access_pending
);
  import rate_table_pkg::*;

  rate_state_t s_q;
  rate_state_t s_d;

  logic cmd_wr;
  logic cnt_rd;
  logic [1:0] cmd_type;
  logic [4:0] cmd_addr;
  logic addr_ok;

  // Command field decode
  assign cmd_wr = reg_wr && (reg_addr == `RATE_TABLE_COMMAND_IDX);
  assign cnt_rd = reg_rd && (reg_addr == `PORT0_FILTERED_COUNT_IDX);
  assign cmd_type = s_q.command[`CMD_TYPE_HI:`CMD_TYPE_LO];
  assign cmd_addr = s_q.command[`CMD_ADDR_HI:`CMD_ADDR_LO];
  // Out-of-range rate addresses are dropped rather than aliased
  assign addr_ok = (cmd_addr < 5'(`RATE_ENTRIES));

  // Next-state logic for the whole block
  always_comb begin
    s_d = s_q;
    s_d.rsp_valid = 1'b0;

    // Register writes; reserved bits are simply not stored
    if (reg_wr && reg_addr == `RATE_WRITE_DATA_IDX) begin
      s_d.write_data = reg_wdata[15:0];
    end

    // Access sequencer; commands issued while busy are ignored
    unique case (s_q.st)
      ACC_IDLE: begin
        if (cmd_wr) begin
          s_d.command = reg_wdata[7:0];
          s_d.st = ACC_BUSY;
          s_d.lat = `RATE_ACCESS_CYCLES - 2'h1;
        end
      end
      ACC_BUSY: begin
        if (s_q.lat != 2'h0) begin
          s_d.lat = s_q.lat - 2'h1;
        end else begin
          s_d.st = ACC_IDLE;
          if (s_q.command[`CMD_DIR_BIT]) begin
            unique case (cmd_type)
              `TYPE_COMMITTED_RATE: begin
                s_d.read_data = addr_ok ? s_q.committed_rate_entry[cmd_addr] : 16'h0000;
              end
              `TYPE_COMMITTED_BURST: s_d.read_data = s_q.committed_burst_size;
              `TYPE_EXCESS_BURST: s_d.read_data = s_q.excess_burst_size;
              `TYPE_RESERVED: begin
                // Nothing fetched, so the last read data stays on show
                s_d.read_data = s_q.read_data;
              end
            endcase
          end else begin
            unique case (cmd_type)
              `TYPE_COMMITTED_RATE: begin
                if (addr_ok) begin
                  s_d.committed_rate_entry[cmd_addr] = s_q.write_data;
                end
              end
              `TYPE_COMMITTED_BURST: s_d.committed_burst_size = s_q.write_data;
              `TYPE_EXCESS_BURST: s_d.excess_burst_size = s_q.write_data;
              `TYPE_RESERVED: begin
                // No effect; a data write in this same cycle must not be undone
                s_d.st = ACC_IDLE;
              end
            endcase
          end
        end
      end
    endcase

    // Buckets refill only while below the size, so a lowered size caps
    // a full bucket only after traffic has drained it underneath
    if (tok_consume) begin
      s_d.committed_tokens = (s_q.committed_tokens > tok_bytes) ?
        s_q.committed_tokens - tok_bytes : 16'h0000;
      s_d.excess_tokens = (s_q.excess_tokens > tok_bytes) ?
        s_q.excess_tokens - tok_bytes : 16'h0000;
    end else if (tok_refill) begin
      if (s_q.committed_tokens < s_q.committed_burst_size) begin
        s_d.committed_tokens = s_q.committed_tokens + 16'h0001;
      end
      if (s_q.excess_tokens < s_q.excess_burst_size) begin
        s_d.excess_tokens = s_q.excess_tokens + 16'h0001;
      end
    end

    // Filtered counter: a packet in the clearing cycle still counts
    if (cnt_rd) begin
      s_d.filtered_count = pkt_filtered ? 32'h0000_0001 : 32'h0000_0000;
    end else if (pkt_filtered && s_q.filtered_count != `COUNT_MAX) begin
      s_d.filtered_count = s_q.filtered_count + 32'h0000_0001;
    end

    // Read answer one cycle after the strobe; unmapped indices read zero
    if (reg_rd) begin
      s_d.rsp_valid = 1'b1;
      unique case (reg_addr)
        `RATE_TABLE_COMMAND_IDX: s_d.rsp_data = {24'h000000, s_q.command};
        `RATE_CMD_STATUS_IDX: s_d.rsp_data = {31'h0, s_q.st == ACC_BUSY};
        `RATE_WRITE_DATA_IDX: s_d.rsp_data = {16'h0000, s_q.write_data};
        `RATE_READ_DATA_IDX: s_d.rsp_data = {16'h0000, s_q.read_data};
        `PORT0_FILTERED_COUNT_IDX: s_d.rsp_data = s_q.filtered_count;
        default: s_d.rsp_data = 32'h0000_0000;
      endcase
    end
  end

  // State register; reset loads all documented defaults
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      s_q.st <= ACC_IDLE;
      s_q.lat <= 2'h0;
      s_q.command <= 8'h00;
      s_q.write_data <= 16'h0000;
      s_q.read_data <= 16'h0000;
      s_q.committed_rate_entry <= {`RATE_ENTRIES{`RATE_ENTRY_RESET}};
      s_q.committed_burst_size <= `BURST_SIZE_RESET;
      s_q.excess_burst_size <= `BURST_SIZE_RESET;
      s_q.filtered_count <= 32'h0000_0000;
      s_q.rsp_data <= 32'h0000_0000;
      s_q.rsp_valid <= 1'b0;
      s_q.committed_tokens <= `BURST_SIZE_RESET;
      s_q.excess_tokens <= `BURST_SIZE_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs come straight from the state flops
  assign reg_rdata = s_q.rsp_data;
  assign reg_rvalid = s_q.rsp_valid;
  assign committed_rate_table = s_q.committed_rate_entry;
  assign committed_burst = s_q.committed_burst_size;
  assign excess_burst = s_q.excess_burst_size;
  assign committed_tokens = s_q.committed_tokens;
  assign excess_tokens = s_q.excess_tokens;
  assign access_pending = (s_q.st == ACC_BUSY);

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  // Checks on the access sequencer
  pend_launch_a: assert property (
    (cmd_wr && !access_pending) |=> access_pending)
    else $error("command write did not raise pending");

  pend_clear_a: assert property (
    $rose(access_pending) |-> ##1 access_pending ##1 !access_pending)
    else $error("pending did not clear after two cycles");

  burst_write_a: assert property (
    ($fell(access_pending) && !$past(s_q.command[7]) && $past(cmd_type) == 2'h2)
      |-> committed_burst == $past(s_q.write_data))
    else $error("committed burst write not stored");

  rate_read_a: assert property (
    ($fell(access_pending) && $past(s_q.command[7]) && $past(cmd_type) == 2'h1
      && $past(cmd_addr) < 5'h18)
      |-> s_q.read_data == $past(s_q.committed_rate_entry[cmd_addr]))
    else $error("committed rate read returned wrong data");

  // Checks on the register answers
  upper_zero_a: assert property (
    (reg_rd && (reg_addr == `RATE_CMD_STATUS_IDX || reg_addr == `RATE_WRITE_DATA_IDX
      || reg_addr == `RATE_READ_DATA_IDX)) |=> reg_rvalid && reg_rdata[31:16] == 16'h0000)
    else $error("reserved upper bits not zero");

  // Checks on the filtered counter
  count_clear_a: assert property (
    (cnt_rd && !pkt_filtered) |=> reg_rdata == $past(s_q.filtered_count)
      && s_q.filtered_count == 32'h0000_0000)
    else $error("counter not cleared by read");

  count_inc_a: assert property (
    (!cnt_rd && pkt_filtered && s_q.filtered_count != 32'hffff_ffff)
      |=> s_q.filtered_count == $past(s_q.filtered_count) + 32'h0000_0001)
    else $error("counter did not increment");

  count_sat_a: assert property (
    (!cnt_rd && s_q.filtered_count == 32'hffff_ffff) |=> s_q.filtered_count == 32'hffff_ffff)
    else $error("counter wrapped");

  // Checks on the token buckets
  bucket_cap_a: assert property (
    (committed_tokens > $past(committed_tokens))
      |-> $past(committed_tokens) < $past(committed_burst))
    else $error("committed bucket refilled above size");

  excess_cap_a: assert property (
    (excess_tokens > $past(excess_tokens)) |-> $past(excess_tokens) < $past(excess_burst))
    else $error("excess bucket refilled above size");

  // Consume wins over refill and stops at zero rather than wrapping
  bucket_floor_a: assert property (
    (tok_consume && tok_bytes >= committed_tokens) |=> committed_tokens == 16'h0000)
    else $error("committed bucket did not stop at zero");

  excess_floor_a: assert property (
    (tok_consume && tok_bytes >= excess_tokens) |=> excess_tokens == 16'h0000)
    else $error("excess bucket did not stop at zero");

  // More checks on the access sequencer
  idle_quiet_a: assert property (
    (!access_pending && !cmd_wr) |=> !access_pending)
    else $error("pending rose without a command");

  // A busy sequencer must keep its latched command
  busy_drop_a: assert property (
    (cmd_wr && access_pending) |=> s_q.command == $past(s_q.command))
    else $error("command taken while pending");

  excess_write_a: assert property (
    ($fell(access_pending) && !$past(s_q.command[`CMD_DIR_BIT])
      && $past(cmd_type) == `TYPE_EXCESS_BURST)
      |-> excess_burst == $past(s_q.write_data))
    else $error("excess burst write not stored");

  rate_write_a: assert property (
    ($fell(access_pending) && !$past(s_q.command[`CMD_DIR_BIT])
      && $past(cmd_type) == `TYPE_COMMITTED_RATE && $past(cmd_addr) < 5'h18)
      |-> s_q.committed_rate_entry[$past(cmd_addr)] == $past(s_q.write_data))
    else $error("committed rate write not stored");

  // Out-of-range addresses must not alias onto a real entry
  range_write_a: assert property (
    ($fell(access_pending) && !$past(s_q.command[`CMD_DIR_BIT])
      && $past(cmd_type) == `TYPE_COMMITTED_RATE && $past(cmd_addr) >= 5'h18)
      |-> $stable(committed_rate_table))
    else $error("out of range write changed the table");

  range_read_a: assert property (
    ($fell(access_pending) && $past(s_q.command[`CMD_DIR_BIT])
      && $past(cmd_type) == `TYPE_COMMITTED_RATE && $past(cmd_addr) >= 5'h18)
      |-> s_q.read_data == 16'h0000)
    else $error("out of range read not zero");

  burst_read_a: assert property (
    ($fell(access_pending) && $past(s_q.command[`CMD_DIR_BIT])
      && $past(cmd_type) == `TYPE_COMMITTED_BURST)
      |-> s_q.read_data == $past(committed_burst))
    else $error("committed burst read returned wrong data");

  excess_read_a: assert property (
    ($fell(access_pending) && $past(s_q.command[`CMD_DIR_BIT])
      && $past(cmd_type) == `TYPE_EXCESS_BURST)
      |-> s_q.read_data == $past(excess_burst))
    else $error("excess burst read returned wrong data");

  // A stray reserved command must leave all table state alone
  reserved_type_a: assert property (
    ($fell(access_pending) && $past(cmd_type) == `TYPE_RESERVED)
      |-> $stable(committed_rate_table) && $stable(committed_burst)
      && $stable(excess_burst) && $stable(s_q.read_data))
    else $error("reserved command type had an effect");

  // Read data only moves when a read command completes
  read_hold_a: assert property (
    !($fell(access_pending) && $past(s_q.command[`CMD_DIR_BIT])) |-> $stable(s_q.read_data))
    else $error("read data changed without a read command");

  // More checks on the register answers
  read_answer_a: assert property (
    reg_rd |=> reg_rvalid)
    else $error("read strobe not answered");

  no_answer_a: assert property (
    !reg_rd |=> !reg_rvalid)
    else $error("answer without a read strobe");

  status_read_a: assert property (
    (reg_rd && reg_addr == `RATE_CMD_STATUS_IDX)
      |=> reg_rdata == {31'h0, $past(access_pending)})
    else $error("status read does not show pending");

  cmd_read_a: assert property (
    (reg_rd && reg_addr == `RATE_TABLE_COMMAND_IDX)
      |=> reg_rdata == {24'h000000, $past(s_q.command)})
    else $error("command readback wrong");

  write_data_a: assert property (
    (reg_wr && reg_addr == `RATE_WRITE_DATA_IDX)
      |=> s_q.write_data == $past(reg_wdata[15:0]))
    else $error("write data register not loaded");

  // Between reads the count may only climb, so a wrap would show here
  count_climb_a: assert property (
    !cnt_rd |=> s_q.filtered_count >= $past(s_q.filtered_count))
    else $error("counter went down without a read");

  count_still_a: assert property (
    (!cnt_rd && !pkt_filtered) |=> $stable(s_q.filtered_count))
    else $error("counter moved with no filtered packet");

  count_set_a: assert property (
    (cnt_rd && pkt_filtered) |=> s_q.filtered_count == 32'h0000_0001)
    else $error("packet lost in clearing cycle");

endmodule // ingress_rate_table_access

// file: tb/ingress_rate_table_access_bench.sv
// Self-checking bench for the ingress rate table access block.
// Assumes rate_table_pkg is compiled first and rate_table_regs.svh is on the include path.
`include "rate_table_regs.svh"

module ingress_rate_table_access_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import rate_table_pkg::*;

  logic mclk, rstn, reg_wr, reg_rd, reg_rvalid, pkt_filtered, tok_refill, tok_consume;
  logic access_pending;
  logic [15:0] reg_addr, tok_bytes, committed_burst, excess_burst;
  logic [15:0] committed_tokens, excess_tokens;
  logic [31:0] reg_wdata, reg_rdata;
  rate_table_t committed_rate_table;
  int fails, tests_run, cycles;

  ingress_rate_table_access ingress_rate_table_access_i (.mclk(mclk), .rstn(rstn),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .pkt_filtered(pkt_filtered),
    .tok_refill(tok_refill), .tok_consume(tok_consume), .tok_bytes(tok_bytes),
    .committed_rate_table(committed_rate_table), .committed_burst(committed_burst),
    .excess_burst(excess_burst), .committed_tokens(committed_tokens),
    .excess_tokens(excess_tokens), .access_pending(access_pending));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // Hang guard, well above the roughly 120 cycles the run needs
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      fails++;
      finish_test();
    end
  end

  task automatic finish_test();
    if (fails == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic tick();
    @(posedge mclk);
    #1;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask

  // Strobes are one-cycle pulses; an idle edge always separates two calls
  task automatic reg_write(input logic [15:0] a, input logic [31:0] d);
    tick();
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    tick();
    reg_wr = 1'b0;
  endtask

  task automatic expect_reg(input logic [15:0] a, input logic [31:0] e, input string msg);
    tick();
    reg_addr = a;
    reg_rd = 1'b1;
    tick();
    reg_rd = 1'b0;
    chk({31'h0, reg_rvalid}, 32'h1, "read strobe answer");
    chk(reg_rdata, e, msg);
  endtask

  // Pending must show for exactly two sampled edges after the command edge
  task automatic do_cmd(input logic [7:0] c);
    reg_write(`RATE_TABLE_COMMAND_IDX, {24'h0, c});
    chk({31'h0, access_pending}, 32'h1, "pending first");
    tick();
    chk({31'h0, access_pending}, 32'h1, "pending second");
    tick();
    chk({31'h0, access_pending}, 32'h0, "pending cleared");
  endtask

  task automatic test_reset();
    for (int i = 0; i < `RATE_ENTRIES; i++) begin
      chk({16'h0, committed_rate_table[i]}, 32'h0014, "rate entry reset");
    end
    chk({committed_burst, excess_burst}, 32'h0600_0600, "burst reset");
    chk({committed_tokens, excess_tokens}, 32'h0600_0600, "bucket start");
    expect_reg(`RATE_CMD_STATUS_IDX, 32'h0, "status reset");
    expect_reg(`RATE_WRITE_DATA_IDX, 32'h0, "write data reset");
    expect_reg(`RATE_READ_DATA_IDX, 32'h0, "read data reset");
    expect_reg(`PORT0_FILTERED_COUNT_IDX, 32'h0, "count reset");
  endtask

  // Lowered size must not cut a full bucket, only cap it once drained
  task automatic test_tokens();
    reg_write(`RATE_WRITE_DATA_IDX, 32'h0400);
    do_cmd(8'h40);
    chk({committed_tokens, excess_tokens}, 32'h0600_0600, "bucket not cut");
    tok_bytes = 16'h0202;
    tok_consume = 1'b1;
    tick();
    tok_consume = 1'b0;
    chk({committed_tokens, excess_tokens}, 32'h03fe_03fe, "bucket drained");
    for (int i = 0; i < 4; i++) begin
      tok_refill = 1'b1;
      tick();
      tok_refill = 1'b0;
      tick();
    end
    chk({committed_tokens, excess_tokens}, 32'h0400_0402, "bucket capped");
  endtask

  task automatic test_table();
    reg_write(`RATE_WRITE_DATA_IDX, 32'hffff_1234);
    expect_reg(`RATE_WRITE_DATA_IDX, 32'h1234, "write data upper bits");
    do_cmd(8'h37);
    chk({committed_rate_table[23], committed_rate_table[22]}, 32'h1234_0014, "entry 23");
    reg_write(`RATE_WRITE_DATA_IDX, 32'h0040);
    do_cmd(8'h40);
    chk({committed_burst, excess_burst}, 32'h0040_0600, "committed burst");
    // Excess size stays above the largest packet while committed is cut
    reg_write(`RATE_WRITE_DATA_IDX, 32'h0800);
    do_cmd(8'h60);
    do_cmd(8'h00);
    chk({committed_burst, excess_burst}, 32'h0040_0800, "excess burst");
    chk({16'h0, committed_rate_table[0]}, 32'h0014, "reserved type");
    do_cmd(8'hb7);
    expect_reg(`RATE_READ_DATA_IDX, 32'h1234, "read entry 23");
    do_cmd(8'he0);
    expect_reg(`RATE_READ_DATA_IDX, 32'h0800, "read excess");
    reg_write(`RATE_CMD_STATUS_IDX, 32'hffff_ffff);
    expect_reg(`RATE_CMD_STATUS_IDX, 32'h0, "status read only");
    expect_reg(16'h184f, 32'h0, "unmapped index");
  endtask

  // Second command lands while the first is pending and must be dropped
  task automatic test_pending();
    reg_write(`RATE_WRITE_DATA_IDX, 32'h5555);
    reg_write(`RATE_TABLE_COMMAND_IDX, 32'h20);
    reg_write(`RATE_TABLE_COMMAND_IDX, 32'h21);
    reg_write(`RATE_TABLE_COMMAND_IDX, 32'h22);
    expect_reg(`RATE_CMD_STATUS_IDX, 32'h1, "status pending");
    tick();
    chk({committed_rate_table[1], committed_rate_table[0]}, 32'h0014_5555, "busy drop");
    chk({16'h0, committed_rate_table[2]}, 32'h5555, "entry 2");
  endtask

  task automatic test_counter();
    for (int i = 0; i < 3; i++) begin
      pkt_filtered = 1'b1;
      tick();
      pkt_filtered = 1'b0;
      tick();
    end
    expect_reg(`PORT0_FILTERED_COUNT_IDX, 32'h3, "filtered count");
    expect_reg(`PORT0_FILTERED_COUNT_IDX, 32'h0, "clear on read");
  endtask

  // Out-of-range address, command readback, set-wins clear, bucket floor
  task automatic test_corners();
    reg_write(`RATE_WRITE_DATA_IDX, 32'h7777);
    do_cmd(8'h38);
    chk({committed_rate_table[23], committed_rate_table[0]}, 32'h1234_5555, "no alias");
    do_cmd(8'hb8);
    expect_reg(`RATE_READ_DATA_IDX, 32'h0, "addr 24 read");
    expect_reg(`RATE_TABLE_COMMAND_IDX, 32'hb8, "command readback");
    pkt_filtered = 1'b1;
    tick();
    reg_addr = `PORT0_FILTERED_COUNT_IDX;
    reg_rd = 1'b1;
    tick();
    {reg_rd, pkt_filtered} = 2'h0;
    chk(reg_rdata, 32'h1, "count before clear");
    expect_reg(`PORT0_FILTERED_COUNT_IDX, 32'h1, "set wins over clear");
    tok_bytes = 16'hffff;
    {tok_consume, tok_refill} = 2'h3;
    tick();
    {tok_consume, tok_refill} = 2'h0;
    chk({committed_tokens, excess_tokens}, 32'h0, "bucket floor");
    tok_refill = 1'b1;
    tick();
    tok_refill = 1'b0;
    chk({committed_tokens, excess_tokens}, 32'h0001_0001, "refill from empty");
  endtask

  // Reset in mid-run must restore every default that test_reset checks, and clear the read answer
  task automatic test_mid_reset();
    rstn = 1'b0;
    tick();
    tick();
    rstn = 1'b1;
    chk({31'h0, reg_rvalid}, 32'h0, "no answer after reset");
    chk(reg_rdata, 32'h0, "answer cleared by reset");
    test_reset();
  endtask

  initial begin
    rstn = 1'b0;
    {reg_wr, reg_rd, pkt_filtered, tok_refill, tok_consume} = 5'h0;
    reg_addr = 16'h0;
    reg_wdata = 32'h0;
    tok_bytes = 16'h0;
    repeat (6) @(posedge mclk);
    #1;
    rstn = 1'b1;
    test_reset();
    test_tokens();
    test_table();
    test_pending();
    test_counter();
    test_corners();
    test_mid_reset();
    finish_test();
  end
endmodule // ingress_rate_table_access_bench
